// [logic/pin_mux_pkg.sv]
// constants shared by the pin function multiplexer for package pins 1 to 7
// What this block does
// - after reset every pin runs its primary function
// - alternative needs peripheral enable plus matching select
// - port mode direction is set per pin
// - pin 1 defaults to test clock, alternative port_d_bit_two
// - reset pin low holds device in reset
// - internal reset releases synchronously after fixed count
// - pin 2 as port_d_bit_four no longer resets
// - pin 2 defaults to reset input function
// - pins 3 to 7 default to port bits
// - clock output source follows clock_output_source_select bits
// - serial0_transmit is output or single-wire line
// - pins 5, 6 variant: crossbar outputs or timer B
// - pin 6 offers comparator D, and pulse X outside the second variant
// - pin 7 offers timer A, comparator A, receive, clock
package pin_mux_pkg;

  // ----------------------------------------------------------------
  // pin geometry
  // ----------------------------------------------------------------
  localparam int PIN_COUNT = 7;
  localparam int SEL_WIDTH = 2;
  localparam int PIN_TEST_CLOCK = 0;
  localparam int PIN_RESET = 1;
  localparam int PIN_CRYSTAL_IN = 2;
  localparam int PIN_CRYSTAL_OUT = 3;
  localparam int PIN_SERIAL_TX = 4;
  localparam int PIN_SERIAL_RX = 5;
  localparam int PIN_TIMER_A = 6;

  // ----------------------------------------------------------------
  // alternative select codes, one set per pin
  // ----------------------------------------------------------------
  localparam logic [1:0] ALT_PORT = 2'h0;         // pins 1 and 2
  localparam logic [1:0] ALT_CRYSTAL = 2'h0;      // pins 3 and 4
  localparam logic [1:0] ALT_CLOCK_IN_ZERO = 2'h1;
  localparam logic [1:0] ALT_TRANSMIT = 2'h0;     // pin 5
  localparam logic [1:0] ALT_VARIANT_OUT = 2'h1;  // pins 5 and 6
  localparam logic [1:0] ALT_CROSSBAR_IN = 2'h2;
  localparam logic [1:0] ALT_CLOCK_OUT = 2'h3;
  localparam logic [1:0] ALT_RECEIVE = 2'h0;      // pin 6
  localparam logic [1:0] ALT_COMPARATOR_D = 2'h2;
  localparam logic [1:0] ALT_PULSE_X = 2'h3;
  localparam logic [1:0] ALT_TIMER_A = 2'h0;      // pin 7
  localparam logic [1:0] ALT_COMPARATOR_A = 2'h1;
  localparam logic [1:0] ALT_RECEIVE_SEVEN = 2'h2;
  localparam logic [1:0] ALT_CLOCK_IN_ONE = 2'h3;

  // legal select codes per pin, bit n set means code n exists
  localparam logic [3:0] LEGAL_ONE_CODE = 4'h1;
  localparam logic [3:0] LEGAL_TWO_CODES = 4'h3;
  localparam logic [3:0] LEGAL_ALL_CODES = 4'hf;
  localparam logic [3:0] LEGAL_NO_PULSE = 4'h7;

  // ----------------------------------------------------------------
  // levels and timing
  // ----------------------------------------------------------------
  localparam logic IDLE_HIGH = 1'b1;  // serial idle, pulled-up test clock
  localparam logic IDLE_LOW = 1'b0;
  localparam logic [7:0] RESET_RELEASE_CYCLES = 8'h20;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [7:0] COUNT_ZERO = 8'h00;

endpackage

// [logic/reset_release.sv]
// internal reset generator with synchronous, counted release
`timescale 1ns/100ps
module reset_release (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic resetRequest,
  output logic internalReset_n
);
  import pin_mux_pkg::*;

  typedef struct packed {
    logic [7:0] count;
    logic releaseDone;
  } release_s;

  release_s state;
  release_s next_state;

  // ----------------------------------------------------------------
  // release counter
  // ----------------------------------------------------------------
  // any request restarts the count, so a bouncing source cannot cut it short
  always_comb begin
    next_state = state;
    if (resetRequest) begin
      next_state.count = RESET_RELEASE_CYCLES;
      next_state.releaseDone = 1'b0;
    end else if (state.count != COUNT_ZERO) begin
      next_state.count = state.count - COUNT_ONE;
      next_state.releaseDone = (state.count == COUNT_ONE);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{count: RESET_RELEASE_CYCLES, releaseDone: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign internalReset_n = state.releaseDone;

endmodule

// [logic/pin_function_mux.sv]
// pin function multiplexer for package pins 1 to 7
`timescale 1ns/100ps
module pin_function_mux #(
  parameter bit SECOND_VARIANT = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] padIn,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] padOut,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] padOe,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] periphEnable,
  input wire logic [pin_mux_pkg::PIN_COUNT*pin_mux_pkg::SEL_WIDTH-1:0] periphSelect,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] gpioOut,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] gpioDir,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] gpioIn,
  input wire logic serialTx,
  input wire logic serialTxDrive,
  input wire logic serialSingleWire,
  input wire logic crossbarOutEleven,
  input wire logic crossbarOutTen,
  input wire logic [1:0] timerBOut,
  input wire logic [1:0] timerBOe,
  input wire logic timerAOut,
  input wire logic timerAOe,
  input wire logic comparatorAOut,
  input wire logic comparatorDOut,
  input wire logic pulseXOut,
  input wire logic pulseXOe,
  input wire logic [3:0] clockSources,
  input wire logic [1:0] clockOutSourceSelect,
  input wire logic watchdogReset,
  input wire logic softwareReset,
  output logic testClock,
  output logic serialRx,
  output logic crossbarInTwo,
  output logic timerAIn,
  output logic [1:0] timerBIn,
  output logic pulseCaptureX,
  output logic extClockInZero,
  output logic extClockInOne,
  output logic crystalConnect,
  output logic internalReset_n
);
  import pin_mux_pkg::*;

  typedef struct packed {
    logic [PIN_COUNT-1:0] padSync1;
    logic [PIN_COUNT-1:0] padSync2;
    logic [PIN_COUNT-1:0] padOut;
    logic [PIN_COUNT-1:0] padOe;
    logic [PIN_COUNT-1:0] gpioIn;
    logic testClock;
    logic serialRx;
    logic crossbarInTwo;
    logic timerAIn;
    logic [1:0] timerBIn;
    logic pulseCaptureX;
    logic extClockInZero;
    logic extClockInOne;
    logic crystalConnect;
  } mux_s;

  mux_s state;
  mux_s next_state;
  logic resetRequest;
  logic chipReady_n;

  // ----------------------------------------------------------------
  // select decoding
  // ----------------------------------------------------------------
  // returns {alternative active, code}; an undefined code falls back to primary
  function automatic logic [2:0] pickAlt(input logic inReset, input logic en,
                                         input logic [1:0] sel, input logic [3:0] legal);
    logic ok;
    ok = !inReset && en && legal[sel];
    return {ok, sel};
  endfunction

  function automatic logic [1:0] selOf(input logic [PIN_COUNT*SEL_WIDTH-1:0] all, input int pin);
    return all[pin*SEL_WIDTH +: SEL_WIDTH];
  endfunction

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  // the reset pin only counts while pin 2 is in its primary role
  logic [2:0] altReset;
  assign altReset = pickAlt(!chipReady_n, periphEnable[PIN_RESET],
                            selOf(periphSelect, PIN_RESET), LEGAL_ONE_CODE);
  assign resetRequest = (!altReset[2] && !state.padSync2[PIN_RESET])
                        || watchdogReset || softwareReset;

  reset_release u_reset_release (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .resetRequest(resetRequest),
    .internalReset_n(chipReady_n)
  );

  // ----------------------------------------------------------------
  // pad and peripheral routing
  // ----------------------------------------------------------------
  always_comb begin
    logic inReset;
    logic [2:0] a1;
    logic [2:0] a3;
    logic [2:0] a4;
    logic [2:0] a5;
    logic [2:0] a6;
    logic [2:0] a7;
    logic [PIN_COUNT-1:0] pin;
    logic rxFive;
    logic rxSix;
    logic rxSeven;
    inReset = !chipReady_n;  // while in reset every pin sits in its primary role
    rxFive = IDLE_HIGH;
    rxSix = IDLE_HIGH;
    rxSeven = IDLE_HIGH;
    a1 = pickAlt(inReset, periphEnable[PIN_TEST_CLOCK], selOf(periphSelect, PIN_TEST_CLOCK),
                 LEGAL_ONE_CODE);
    a3 = pickAlt(inReset, periphEnable[PIN_CRYSTAL_IN], selOf(periphSelect, PIN_CRYSTAL_IN),
                 LEGAL_TWO_CODES);
    a4 = pickAlt(inReset, periphEnable[PIN_CRYSTAL_OUT], selOf(periphSelect, PIN_CRYSTAL_OUT),
                 LEGAL_ONE_CODE);
    a5 = pickAlt(inReset, periphEnable[PIN_SERIAL_TX], selOf(periphSelect, PIN_SERIAL_TX),
                 LEGAL_ALL_CODES);
    a6 = pickAlt(inReset, periphEnable[PIN_SERIAL_RX], selOf(periphSelect, PIN_SERIAL_RX),
                 SECOND_VARIANT ? LEGAL_NO_PULSE : LEGAL_ALL_CODES);
    a7 = pickAlt(inReset, periphEnable[PIN_TIMER_A], selOf(periphSelect, PIN_TIMER_A),
                 LEGAL_ALL_CODES);
    pin = state.padSync2;
    next_state = state;

    // two-stage synchronisers on every pad
    next_state.padSync1 = padIn;
    next_state.padSync2 = state.padSync1;
    next_state.gpioIn = pin;

    // port mode by default: each pin owns its own direction bit
    next_state.padOut = gpioOut;
    next_state.padOe = gpioDir;

    // pin 1: test clock in, or port_d_bit_two
    if (!a1[2]) begin
      next_state.padOe[PIN_TEST_CLOCK] = 1'b0;
    end
    next_state.testClock = a1[2] ? IDLE_HIGH : pin[PIN_TEST_CLOCK];

    // pin 2: reset input, or port_d_bit_four
    if (!altReset[2]) begin
      next_state.padOe[PIN_RESET] = 1'b0;
    end

    // pins 3 and 4: port_c_bit_zero/one, crystal, external clock zero
    if (a3[2]) begin
      next_state.padOe[PIN_CRYSTAL_IN] = 1'b0;
    end
    if (a4[2]) begin
      next_state.padOe[PIN_CRYSTAL_OUT] = 1'b0;
    end
    // oscillator only connects when both crystal pins are handed over
    next_state.crystalConnect = a3[2] && a3[1:0] == ALT_CRYSTAL && a4[2];
    next_state.extClockInZero = (a3[2] && a3[1:0] == ALT_CLOCK_IN_ZERO) ? pin[PIN_CRYSTAL_IN] : IDLE_LOW;

    // pin 5: port_c_bit_two, transmit, variant output, crossbar in, clock out
    next_state.crossbarInTwo = IDLE_LOW;
    next_state.timerBIn = {IDLE_LOW, IDLE_LOW};
    if (a5[2]) begin
      unique case (a5[1:0])
        ALT_TRANSMIT: begin
          next_state.padOut[PIN_SERIAL_TX] = serialTx;
          next_state.padOe[PIN_SERIAL_TX] = serialSingleWire ? serialTxDrive : 1'b1;
          rxFive = serialSingleWire ? pin[PIN_SERIAL_TX] : IDLE_HIGH;
        end
        ALT_VARIANT_OUT: begin
          if (SECOND_VARIANT) begin
            next_state.padOut[PIN_SERIAL_TX] = timerBOut[0];
            next_state.padOe[PIN_SERIAL_TX] = timerBOe[0];
            next_state.timerBIn[0] = pin[PIN_SERIAL_TX];
          end else begin
            next_state.padOut[PIN_SERIAL_TX] = crossbarOutEleven;
            next_state.padOe[PIN_SERIAL_TX] = 1'b1;
          end
        end
        ALT_CROSSBAR_IN: begin
          next_state.padOe[PIN_SERIAL_TX] = 1'b0;
          next_state.crossbarInTwo = pin[PIN_SERIAL_TX];
        end
        ALT_CLOCK_OUT: begin
          next_state.padOut[PIN_SERIAL_TX] = clockSources[clockOutSourceSelect];
          next_state.padOe[PIN_SERIAL_TX] = 1'b1;
        end
      endcase
    end

    // pin 6: port_f_bit_eight, receive, variant output, comparator D, pulse X
    next_state.pulseCaptureX = IDLE_LOW;
    if (a6[2]) begin
      unique case (a6[1:0])
        ALT_RECEIVE: begin
          next_state.padOe[PIN_SERIAL_RX] = 1'b0;
          rxSix = pin[PIN_SERIAL_RX];
        end
        ALT_VARIANT_OUT: begin
          if (SECOND_VARIANT) begin
            next_state.padOut[PIN_SERIAL_RX] = timerBOut[1];
            next_state.padOe[PIN_SERIAL_RX] = timerBOe[1];
            next_state.timerBIn[1] = pin[PIN_SERIAL_RX];
          end else begin
            next_state.padOut[PIN_SERIAL_RX] = crossbarOutTen;
            next_state.padOe[PIN_SERIAL_RX] = 1'b1;
          end
        end
        ALT_COMPARATOR_D: begin
          next_state.padOut[PIN_SERIAL_RX] = comparatorDOut;
          next_state.padOe[PIN_SERIAL_RX] = 1'b1;
        end
        ALT_PULSE_X: begin
          next_state.padOut[PIN_SERIAL_RX] = pulseXOut;
          next_state.padOe[PIN_SERIAL_RX] = pulseXOe;
          next_state.pulseCaptureX = pin[PIN_SERIAL_RX];
        end
      endcase
    end

    // pin 7: port_c_bit_three, timer A, comparator A, receive, clock one
    next_state.timerAIn = IDLE_LOW;
    next_state.extClockInOne = IDLE_LOW;
    if (a7[2]) begin
      unique case (a7[1:0])
        ALT_TIMER_A: begin
          next_state.padOut[PIN_TIMER_A] = timerAOut;
          next_state.padOe[PIN_TIMER_A] = timerAOe;
          next_state.timerAIn = pin[PIN_TIMER_A];
        end
        ALT_COMPARATOR_A: begin
          next_state.padOut[PIN_TIMER_A] = comparatorAOut;
          next_state.padOe[PIN_TIMER_A] = 1'b1;
        end
        ALT_RECEIVE_SEVEN: begin
          next_state.padOe[PIN_TIMER_A] = 1'b0;
          rxSeven = pin[PIN_TIMER_A];
        end
        ALT_CLOCK_IN_ONE: begin
          next_state.padOe[PIN_TIMER_A] = 1'b0;
          next_state.extClockInOne = pin[PIN_TIMER_A];
        end
      endcase
    end

    // receive idles high; if software routes it to two pins a low on either wins
    next_state.serialRx = rxFive & rxSix & rxSeven;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // pads come up released and every peripheral input at its idle level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{padSync1: '1, padSync2: '1, padOut: '0, padOe: '0, gpioIn: '0,
                 testClock: IDLE_HIGH, serialRx: IDLE_HIGH, crossbarInTwo: IDLE_LOW,
                 timerAIn: IDLE_LOW, timerBIn: '0, pulseCaptureX: IDLE_LOW,
                 extClockInZero: IDLE_LOW, extClockInOne: IDLE_LOW, crystalConnect: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign padOut = state.padOut;
  assign padOe = state.padOe;
  assign gpioIn = state.gpioIn;
  assign testClock = state.testClock;
  assign serialRx = state.serialRx;
  assign crossbarInTwo = state.crossbarInTwo;
  assign timerAIn = state.timerAIn;
  assign timerBIn = state.timerBIn;
  assign pulseCaptureX = state.pulseCaptureX;
  assign extClockInZero = state.extClockInZero;
  assign extClockInOne = state.extClockInOne;
  assign crystalConnect = state.crystalConnect;
  assign internalReset_n = chipReady_n;

endmodule

// [bench/board_pins.sv]
// board-level model of what hangs on package pins 1 to 7
`timescale 1ns/100ps
module board_pins (
  input wire logic core_clk,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] padOut,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] padOe,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] boardLevel,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] boardDrive,
  output logic [pin_mux_pkg::PIN_COUNT-1:0] padIn
);
  import pin_mux_pkg::*;
  logic [PIN_COUNT-1:0] floatLevel = '0;
  // floating pins wander every cycle so a stale sample never passes
  always @(posedge core_clk) floatLevel <= ~floatLevel;
  // design wins where it drives, then the board, then the pin 1 pull-up
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      padIn[i] = padOe[i] ? padOut[i] : boardDrive[i] ? boardLevel[i] :
        (i == PIN_TEST_CLOCK) ? IDLE_HIGH : floatLevel[i];
    end
  end
endmodule

// [bench/pin_mux_properties.sv]
// concurrent checks on the pin function multiplexer ports
`timescale 1ns/100ps
module pin_mux_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] padIn,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] padOut,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] padOe,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] periphEnable,
  input wire logic [pin_mux_pkg::PIN_COUNT*pin_mux_pkg::SEL_WIDTH-1:0] periphSelect,
  input wire logic [pin_mux_pkg::PIN_COUNT-1:0] gpioDir,
  input wire logic serialTx,
  input wire logic serialTxDrive,
  input wire logic serialSingleWire,
  input wire logic [3:0] clockSources,
  input wire logic [1:0] clockOutSourceSelect,
  input wire logic watchdogReset,
  input wire logic softwareReset,
  input wire logic testClock,
  input wire logic internalReset_n
);
  import pin_mux_pkg::*;
  logic [7:0] sinceRelease;
  logic selClk;
  assign selClk = clockSources[clockOutSourceSelect];
  // edges since rst_n let go; saturates so it never wraps into a false window
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sinceRelease <= COUNT_ZERO;
    end else if (sinceRelease != 8'hff) begin
      sinceRelease <= sinceRelease + COUNT_ONE;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // clock-out and transmit selections: chosen while running, still running one edge on
  sequence sClkSel;
    internalReset_n && periphEnable[4] && periphSelect[9:8] == ALT_CLOCK_OUT ##1 internalReset_n;
  endsequence
  sequence sTxSel;
    internalReset_n && periphEnable[4] && periphSelect[9:8] == ALT_TRANSMIT ##1 internalReset_n;
  endsequence
  sequence sPinLow;
    (!padIn[1] && !periphEnable[1]) ##1 !periphEnable[1] [*3];
  endsequence
  sequence sPortTwo;
    internalReset_n && periphEnable[1] && periphSelect[3:2] == ALT_PORT && !watchdogReset && !softwareReset;
  endsequence
  port_mode_dir_a: assert property (
    periphEnable == '0 |=> padOe == ($past(gpioDir) & 7'h7c)) else $error("port mode direction wrong");
  test_clock_a: assert property (
    !periphEnable[0] [*4] |-> testClock == $past(padIn[0], 3)) else $error("test clock not following pin");
  clock_out_a: assert property (
    sClkSel |-> padOe[4] && padOut[4] == $past(selClk)) else $error("clock output source wrong");
  transmit_pin_a: assert property (
    sTxSel |-> padOe[4] == ($past(serialSingleWire) ? $past(serialTxDrive) : 1'b1) &&
      (!padOe[4] || padOut[4] == $past(serialTx))) else $error("transmit pin wrong");
  release_hold_a: assert property (
    sinceRelease < RESET_RELEASE_CYCLES |-> !internalReset_n) else $error("internal reset released early");
  reset_request_a: assert property (
    watchdogReset || softwareReset |-> ##3 !internalReset_n) else $error("reset request ignored");
  reset_pin_a: assert property (
    sPinLow |-> ##2 !internalReset_n) else $error("reset pin low ignored");
  port_reset_off_a: assert property (
    sPortTwo [*6] |=> internalReset_n) else $error("port mode pin still resets");
endmodule
bind pin_function_mux pin_mux_properties chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .padIn(padIn), .padOut(padOut), .padOe(padOe),
  .periphEnable(periphEnable), .periphSelect(periphSelect), .gpioDir(gpioDir), .serialTx(serialTx),
  .serialTxDrive(serialTxDrive), .serialSingleWire(serialSingleWire), .clockSources(clockSources),
  .clockOutSourceSelect(clockOutSourceSelect), .watchdogReset(watchdogReset),
  .softwareReset(softwareReset), .testClock(testClock), .internalReset_n(internalReset_n)
);

// [bench/pin_function_mux_test.sv]
// self-checking bench for the pin function multiplexer
`timescale 1ns/100ps
module pin_function_mux_test;
  import pin_mux_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [PIN_COUNT-1:0] padIn, padOut, padOe, periphEnable, gpioOut, gpioDir, gpioIn, boardLevel, boardDrive;
  logic [PIN_COUNT*SEL_WIDTH-1:0] periphSelect;
  logic [6:0] src;
  logic serialTxDrive, serialSingleWire, watchdogReset, softwareReset;
  logic [3:0] clockSources;
  logic [1:0] clockOutSourceSelect;
  logic testClock, extClockInZero, crossbarInTwo, serialRx, extClockInOne, internalReset_n;
  logic [5:0] ins;
  logic pulseCaptureX, timerAIn, crystalConnect, periphDrive;
  logic [1:0] timerBIn;
  int bad_count = 0;
  int num_checks = 0;
  // entries are {pin, select code, source or sink index}
  logic [7:0] outTable [7] = '{8'h80, 8'h89, 8'haa, 8'hb3, 8'hbc, 8'hc5, 8'hce};
  logic [7:0] inTable [7] = '{8'h48, 8'h91, 8'ha2, 8'hd2, 8'hdb, 8'hc4, 8'hbd};
  assign ins = {pulseCaptureX, timerAIn, extClockInOne, serialRx, crossbarInTwo, extClockInZero};
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;
  pin_function_mux dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .periphEnable(periphEnable), .periphSelect(periphSelect), .gpioOut(gpioOut), .gpioDir(gpioDir),
    .gpioIn(gpioIn), .serialTx(src[0]), .serialTxDrive(serialTxDrive), .serialSingleWire(serialSingleWire),
    .crossbarOutEleven(src[1]), .crossbarOutTen(src[2]), .timerBOut(2'h0), .timerBOe(2'h0),
    .timerAOut(src[5]), .timerAOe(periphDrive), .comparatorAOut(src[6]), .comparatorDOut(src[3]),
    .pulseXOut(src[4]), .pulseXOe(periphDrive), .clockSources(clockSources),
    .clockOutSourceSelect(clockOutSourceSelect), .watchdogReset(watchdogReset), .softwareReset(softwareReset),
    .testClock(testClock), .serialRx(serialRx), .crossbarInTwo(crossbarInTwo), .timerAIn(timerAIn),
    .timerBIn(timerBIn), .pulseCaptureX(pulseCaptureX), .extClockInZero(extClockInZero),
    .extClockInOne(extClockInOne), .crystalConnect(crystalConnect),
    .internalReset_n(internalReset_n)
  );
  board_pins board_u (
    .core_clk(core_clk), .padOut(padOut), .padOe(padOe), .boardLevel(boardLevel),
    .boardDrive(boardDrive), .padIn(padIn)
  );
  // -----------------------------
  // access tasks
  // -----------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic setPin(input logic [2:0] p, input logic [1:0] code);
    periphEnable[p] = 1'b1;
    periphSelect[2*p+:2] = code;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end
  // main sequence
  initial begin
    periphEnable = '0;
    periphSelect = '0;
    gpioOut = 7'h7c;
    gpioDir = '0;
    boardLevel = 7'h7f;
    boardDrive = 7'h03;
    src = '0;
    {serialTxDrive, serialSingleWire, watchdogReset, softwareReset} = 4'h8;
    periphDrive = 1'b1;
    clockSources = '0;
    clockOutSourceSelect = '0;
    repeat (12) @(posedge core_clk);
    #1;
    check("oe_in_reset", 8'h0, {1'b0, padOe});
    rst_n = 1'b1;
    tick(31);
    check("int_reset_held", 8'h0, {7'h0, internalReset_n});
    tick(1);
    check("int_reset_free", 8'h1, {7'h0, internalReset_n});
    for (int k = 0; k < 2; k++) begin
      gpioDir = k ? 7'h2b : 7'h57;
      tick(2);
      check("port_oe", {1'b0, gpioDir & 7'h7c}, {1'b0, padOe});
      check("port_out", {1'b0, gpioDir & 7'h7c}, {1'b0, padOut & padOe});
    end
    for (int v = 0; v < 2; v++) begin
      boardLevel[0] = v[0];
      tick(4);
      check("test_clock", v[7:0], {7'h0, testClock});
      check("gpio_in", v[7:0], {7'h0, gpioIn[0]});
    end
    setPin(0, ALT_PORT);
    gpioDir = 7'h01;
    tick(2);
    check("pin1_port_oe", 8'h1, {7'h0, padOe[0]});
    periphEnable = '0;
    periphSelect[9:8] = ALT_CLOCK_OUT;
    gpioDir = '0;
    tick(2);
    check("select_without_enable", 8'h0, {1'b0, padOe});
    foreach (outTable[i]) for (int v = 0; v < 2; v++) begin
      periphEnable = '0;
      setPin(outTable[i][7:5], outTable[i][4:3]);
      src = v ? 7'h01 << outTable[i][2:0] : ~(7'h01 << outTable[i][2:0]);
      tick(2);
      check("alt_out_oe", 8'h1, {7'h0, padOe[outTable[i][7:5]]});
      check("alt_out_level", v[7:0], {7'h0, padOut[outTable[i][7:5]]});
      check("timer_b_in", 8'h0, {6'h0, timerBIn});
    end
    periphEnable = '0;
    setPin(4, ALT_CLOCK_OUT);
    for (int k = 0; k < 8; k++) begin
      clockOutSourceSelect = k[1:0];
      clockSources = k[2] ? 4'h1 << k[1:0] : ~(4'h1 << k[1:0]);
      tick(2);
      check("clock_out", {7'h0, k[2]}, {7'h0, padOut[4]});
    end
    // peripheral pad drivers off so timer A and capture X see the board
    periphDrive = 1'b0;
    foreach (inTable[i]) for (int v = 0; v < 2; v++) begin
      periphEnable = '0;
      setPin(inTable[i][7:5], inTable[i][4:3]);
      boardDrive = 7'h03 | (7'h01 << inTable[i][7:5]);
      boardLevel[inTable[i][7:5]] = v[0];
      tick(5);
      check("alt_in_level", v[7:0], {7'h0, ins[inTable[i][2:0]]});
    end
    periphEnable = '0;
    boardDrive = 7'h03;
    boardLevel = 7'h7f;
    tick(5);
    check("unselected_inputs", 8'h4, {2'h0, ins});
    setPin(2, ALT_CRYSTAL);
    tick(2);
    check("crystal_half", 8'h0, {7'h0, crystalConnect});
    setPin(3, ALT_CRYSTAL);
    tick(2);
    check("crystal_both", 8'h1, {7'h0, crystalConnect});
    setPin(4, ALT_TRANSMIT);
    {serialSingleWire, serialTxDrive} = 2'h2;
    boardDrive = 7'h13;
    boardLevel[4] = 1'b0;
    tick(5);
    check("single_wire_oe", 8'h0, {7'h0, padOe[4]});
    check("single_wire_rx", 8'h0, {7'h0, serialRx});
    serialTxDrive = 1'b1;
    boardDrive = 7'h03;
    tick(2);
    check("single_wire_drive", 8'h1, {7'h0, padOe[4]});
    periphEnable = '0;
    boardLevel[1] = 1'b0;
    tick(5);
    check("reset_pin_low", 8'h0, {7'h0, internalReset_n});
    boardLevel[1] = 1'b1;
    tick(40);
    check("reset_pin_high", 8'h1, {7'h0, internalReset_n});
    setPin(1, ALT_PORT);
    tick(2);
    boardLevel[1] = 1'b0;
    tick(8);
    check("port_pin_no_reset", 8'h1, {7'h0, internalReset_n});
    boardLevel[1] = 1'b1;
    for (int r = 0; r < 2; r++) begin
      {softwareReset, watchdogReset} = 2'h1 << r;
      tick(1);
      {softwareReset, watchdogReset} = 2'h0;
      tick(3);
      check("request_reset", 8'h0, {7'h0, internalReset_n});
      tick(40);
    end
    complete_run();
  end
endmodule
